// file: core/umif_front_end.v
// mouse input front end: buttons, scroll wheel, option straps, link bring-up
// assumes a packet engine outside that decodes tokens and standard requests
//
// Behaviour
// - a low button input means pressed and a high one means released.
// - each button is debounced for a fixed interval inside 9 to 17 ms.
// - the basic setup watches left, wheel and right buttons.
// - the two wheel phases are decoded as a quadrature pair giving direction.
// - the device ignores bus traffic until the host has issued a bus reset.
// - the device enables its D- pull-up to announce that it is attached.
// - after set-address the device answers only its new address.
// - the device returns device, configuration and report descriptors on request.
// - fiveButtonSel low at the first edge after reset release selects the three-button identity.
// - the five-button setup has its own identity and reads the straps as buttons.
`timescale 1ns/10ps
`include "umif_regs.vh"

module umif_front_end #(
	parameter [`UMIF_DB_CNT_W-1:0] DEBOUNCE_CYC = `UMIF_DEBOUNCE_CYC
) (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// switches, active low; fiveButtonSel is high for the five-button setup
	input wire button_input_1,
	input wire button_input_2,
	input wire button_input_3,
	input wire option_strap_0,
	input wire option_strap_1,
	input wire fiveButtonSel,
	// wheel encoder
	input wire wheel_phase_a,
	input wire wheel_phase_b,
	// packet engine requests
	input wire busResetDet,
	input wire tokValid,
	input wire [6:0] tokAddr,
	input wire setAddrValid,
	input wire [6:0] setAddrVal,
	input wire descReq,
	input wire [7:0] descType,
	input wire reportTake,
	// link control and answers
	output reg dmPullupEn_r,
	output reg tokAccept_r,
	output reg descAck_r,
	output reg descStall_r,
	output reg [1:0] descSel_r,
	output reg [6:0] devAddr_r,
	output reg [1:0] linkState_r,
	output reg enumDone_r,
	// identity
	output reg fiveButtonMode_r,
	output reg [15:0] vendorId_r,
	output reg [15:0] productId_r,
	// movement report
	output reg reportPending_r,
	output reg [4:0] buttonsPressed_r,
	output reg [7:0] wheelDelta_r
);

	// ============================================================
	// configuration capture
	reg rstSeen_r;

	// the mode is caught on the first edge after reset release,
	// never by the reset itself
	always @(posedge clk) begin
		if (sys_rst) begin
			rstSeen_r <= 1'b0;
			fiveButtonMode_r <= 1'b0;
			vendorId_r <= 16'h0000;
			productId_r <= 16'h0000;
		end else if (!rstSeen_r) begin
			rstSeen_r <= 1'b1;
			vendorId_r <= `UMIF_VENDOR_ID;
			if (fiveButtonSel) begin
				fiveButtonMode_r <= 1'b1;
				productId_r <= `UMIF_PRODUCT_5BTN;
			end else begin
				fiveButtonMode_r <= 1'b0;
				productId_r <= `UMIF_PRODUCT_3BTN;
			end
		end
	end

	// ============================================================
	// button debouncers, one per button and strap input
	wire [4:0] rawBtn;
	wire [4:0] stableBtn;
	wire [4:0] btnChanged;

	assign rawBtn = {option_strap_1, option_strap_0, button_input_3, button_input_2,
		button_input_1};

	genvar gi;
	generate
		for (gi = 0; gi < `UMIF_NUM_BTN; gi = gi + 1) begin : g_btn
			umif_debounce #(
				.HOLD_CYC(DEBOUNCE_CYC)
			) u_db (
				.clk(clk),
				.sys_rst(sys_rst),
				.rawLevel(rawBtn[gi]),
				.stableLevel_r(stableBtn[gi]),
				.changed_r(btnChanged[gi])
			);
		end
	endgenerate

	// pressed is low on the pin; in three-button mode the straps sit at the
	// supply and must not show up as buttons
	wire [4:0] pressedNow;
	wire [4:0] btnEnable;
	assign btnEnable = fiveButtonMode_r ? 5'h1f : 5'h07;
	assign pressedNow = (~stableBtn) & btnEnable;
	wire btnEvent;
	assign btnEvent = |(btnChanged & btnEnable);

	// ============================================================
	// wheel quadrature decoder
	reg [1:0] phasePrev_r;
	reg [2:0] subStep_r;
	reg subDir_r;
	wire [1:0] phaseNow;
	reg stepUp;
	reg stepDown;
	reg badJump;

	assign phaseNow = {wheel_phase_a, wheel_phase_b};

	// gray order 00-01-11-10 is one direction, the reverse the other
	always @* begin
		stepUp = 1'b0;
		stepDown = 1'b0;
		badJump = 1'b0;
		case ({phasePrev_r, phaseNow})
			4'h1, 4'h7, 4'he, 4'h8: stepUp = 1'b1;
			4'h2, 4'hb, 4'hd, 4'h4: stepDown = 1'b1;
			4'h3, 4'hc, 4'h6, 4'h9: badJump = 1'b1;
			default: begin
				stepUp = 1'b0;
			end
		endcase
	end

	// sub-steps gather until a whole detent; a reversal or a double jump
	// throws away the partial step so contact chatter cannot add counts
	reg detentUp;
	reg detentDown;
	always @(posedge clk) begin
		if (sys_rst) begin
			phasePrev_r <= 2'h3;
			subStep_r <= 3'h0;
			subDir_r <= 1'b0;
		end else begin
			phasePrev_r <= phaseNow;
			if (badJump) begin
				subStep_r <= 3'h0;
			end else if (stepUp || stepDown) begin
				if (subStep_r != 3'h0 && subDir_r != stepUp) begin
					subStep_r <= 3'h1;
				end else if (subStep_r + 3'h1 >= `UMIF_STEPS_PER_DETENT) begin
					subStep_r <= 3'h0;
				end else begin
					subStep_r <= subStep_r + 3'h1;
				end
				subDir_r <= stepUp;
			end
		end
	end

	always @* begin
		detentUp = 1'b0;
		detentDown = 1'b0;
		if ((stepUp || stepDown) && !(subStep_r != 3'h0 && subDir_r != stepUp) &&
			(subStep_r + 3'h1 >= `UMIF_STEPS_PER_DETENT)) begin
			detentUp = stepUp;
			detentDown = stepDown;
		end
	end

	// ============================================================
	// wheel accumulator, saturating signed 8 bits
	reg [7:0] wheelAcc_r;
	reg [7:0] accBase;
	reg [7:0] wheelAcc_nxt;

	// a detent in the same cycle as a report take is kept for the next one
	always @* begin
		accBase = reportTake ? 8'h00 : wheelAcc_r;
		wheelAcc_nxt = accBase;
		if (detentUp && accBase != `UMIF_WHEEL_MAX) begin
			wheelAcc_nxt = accBase + 8'h01;
		end else if (detentDown && accBase != `UMIF_WHEEL_MIN) begin
			wheelAcc_nxt = accBase - 8'h01;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			wheelAcc_r <= 8'h00;
		end else begin
			wheelAcc_r <= wheelAcc_nxt;
		end
	end

	// ============================================================
	// movement report staging
	reg [4:0] reportedBtn_r;

	// pending rises on any button change or nonzero wheel count, only once
	// the link is enumerated; new events win over a take in the same cycle
	always @(posedge clk) begin
		if (sys_rst) begin
			reportPending_r <= 1'b0;
			buttonsPressed_r <= 5'h00;
			wheelDelta_r <= 8'h00;
			reportedBtn_r <= 5'h00;
		end else begin
			buttonsPressed_r <= pressedNow;
			wheelDelta_r <= wheelAcc_nxt;
			if (reportTake) begin
				reportedBtn_r <= buttonsPressed_r;
			end
			if (linkState_r != `UMIF_ST_ENUMERATED) begin
				reportPending_r <= 1'b0;
			end else if (btnEvent || detentUp || detentDown) begin
				reportPending_r <= 1'b1;
			end else if (reportTake) begin
				reportPending_r <= 1'b0;
			end else if (wheelAcc_r != 8'h00 || pressedNow != reportedBtn_r) begin
				reportPending_r <= 1'b1;
			end
		end
	end

	// ============================================================
	// link state machine
	localparam [1:0] ST_POWERED = `UMIF_ST_POWERED;
	localparam [1:0] ST_DEFAULT = `UMIF_ST_DEFAULT;
	localparam [1:0] ST_ADDRESSED = `UMIF_ST_ADDRESSED;
	localparam [1:0] ST_ENUMERATED = `UMIF_ST_ENUMERATED;

	wire addrHit;
	wire linkLive;
	assign linkLive = rstSeen_r && (linkState_r != ST_POWERED);
	assign addrHit = (tokAddr == devAddr_r);

	// a bus reset from any state returns to default with address zero;
	// nothing is answered while still powered, the host resets first
	always @(posedge clk) begin
		if (sys_rst) begin
			linkState_r <= ST_POWERED;
			devAddr_r <= `UMIF_DEFAULT_ADDR;
			dmPullupEn_r <= 1'b0;
			enumDone_r <= 1'b0;
		end else begin
			dmPullupEn_r <= rstSeen_r;
			if (busResetDet) begin
				linkState_r <= ST_DEFAULT;
				devAddr_r <= `UMIF_DEFAULT_ADDR;
				enumDone_r <= 1'b0;
			end else begin
				case (linkState_r)
					ST_POWERED: begin
						linkState_r <= ST_POWERED;
					end
					ST_DEFAULT: begin
						if (setAddrValid && setAddrVal != `UMIF_DEFAULT_ADDR) begin
							devAddr_r <= setAddrVal;
							linkState_r <= ST_ADDRESSED;
						end
					end
					ST_ADDRESSED: begin
						if (setAddrValid) begin
							devAddr_r <= setAddrVal;
						end
						if (descReq && addrHit && descType == `UMIF_DESC_HID_REPORT) begin
							linkState_r <= ST_ENUMERATED;
							enumDone_r <= 1'b1;
						end
					end
					ST_ENUMERATED: begin
						enumDone_r <= 1'b1;
					end
					default: begin
						linkState_r <= ST_POWERED;
					end
				endcase
			end
		end
	end

	// ============================================================
	// token filter and descriptor answers
	always @(posedge clk) begin
		if (sys_rst) begin
			tokAccept_r <= 1'b0;
			descAck_r <= 1'b0;
			descStall_r <= 1'b0;
			descSel_r <= `UMIF_SEL_NONE;
		end else begin
			tokAccept_r <= tokValid && linkLive && addrHit && !busResetDet;
			descAck_r <= 1'b0;
			descStall_r <= 1'b0;
			if (descReq && linkLive && addrHit && !busResetDet) begin
				case (descType)
					`UMIF_DESC_DEVICE: begin
						descAck_r <= 1'b1;
						descSel_r <= `UMIF_SEL_DEVICE;
					end
					`UMIF_DESC_CONFIG: begin
						descAck_r <= 1'b1;
						descSel_r <= `UMIF_SEL_CONFIG;
					end
					`UMIF_DESC_HID_REPORT: begin
						descAck_r <= 1'b1;
						descSel_r <= `UMIF_SEL_REPORT;
					end
					default: begin
						descStall_r <= 1'b1;
						descSel_r <= `UMIF_SEL_NONE;
					end
				endcase
			end
		end
	end

endmodule // umif_front_end

// file: shared/umif_regs.vh
// constants for the mouse input front end: timing counts, modes, codes
// assumes a single 250 MHz clock and a synchronous active-high reset
`ifndef UMIF_REGS_VH
`define UMIF_REGS_VH

// ============================================================
// clock and debounce timing
`define UMIF_CLK_PERIOD_NS 4
`define UMIF_DEBOUNCE_MS 10
// 10 ms at a 4 ns clock, sized to the hold counter so no bits are lost
`define UMIF_DEBOUNCE_CYC 22'h2625a0
`define UMIF_DB_CNT_W 22

// ============================================================
// button and wheel layout
`define UMIF_NUM_BTN 5
`define UMIF_BTN_LEFT 0
`define UMIF_BTN_WHEEL 1
`define UMIF_BTN_RIGHT 2
`define UMIF_BTN_FOURTH 3
`define UMIF_BTN_FIFTH 4
`define UMIF_STEPS_PER_DETENT 3'h2
`define UMIF_WHEEL_MAX 8'h7f
`define UMIF_WHEEL_MIN 8'h81

// ============================================================
// identity codes (values arbitrary, not tied to any product)
`define UMIF_VENDOR_ID 16'h1a2b
`define UMIF_PRODUCT_3BTN 16'h0a01
`define UMIF_PRODUCT_5BTN 16'h0a02

// ============================================================
// descriptor type codes as carried in a get-descriptor request
`define UMIF_DESC_DEVICE 8'h01
`define UMIF_DESC_CONFIG 8'h02
`define UMIF_DESC_HID_REPORT 8'h22
`define UMIF_SEL_NONE 2'h0
`define UMIF_SEL_DEVICE 2'h1
`define UMIF_SEL_CONFIG 2'h2
`define UMIF_SEL_REPORT 2'h3

// ============================================================
// link states
`define UMIF_ST_POWERED 2'h0
`define UMIF_ST_DEFAULT 2'h1
`define UMIF_ST_ADDRESSED 2'h2
`define UMIF_ST_ENUMERATED 2'h3
`define UMIF_DEFAULT_ADDR 7'h00

`endif

// file: core/umif_debounce.v
// one switch debouncer: reports a new level only after it held steady
// assumes the raw input is already synchronous to clk
`timescale 1ns/10ps
`include "umif_regs.vh"

module umif_debounce #(
	parameter [`UMIF_DB_CNT_W-1:0] HOLD_CYC = `UMIF_DEBOUNCE_CYC
) (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// switch side
	input wire rawLevel,
	// filtered side
	output reg stableLevel_r,
	output reg changed_r
);

	// ============================================================
	// hold counter
	reg [`UMIF_DB_CNT_W-1:0] holdCnt_r;

	// restart the count whenever the raw level agrees with the stable one;
	// bounces shorter than the hold time therefore never reach the output
	always @(posedge clk) begin
		if (sys_rst) begin
			holdCnt_r <= {`UMIF_DB_CNT_W{1'b0}};
			stableLevel_r <= 1'b1; // idle high, released
			changed_r <= 1'b0;
		end else if (rawLevel == stableLevel_r) begin
			holdCnt_r <= {`UMIF_DB_CNT_W{1'b0}};
			changed_r <= 1'b0;
		end else if (holdCnt_r >= HOLD_CYC - 1'b1) begin
			holdCnt_r <= {`UMIF_DB_CNT_W{1'b0}};
			stableLevel_r <= rawLevel;
			changed_r <= 1'b1;
		end else begin
			holdCnt_r <= holdCnt_r + 1'b1;
			changed_r <= 1'b0;
		end
	end

endmodule // umif_debounce

// file: dv/umif_fe_chk.sv
// checker for the mouse front end link, identity and strap outputs
// assumes it is bound to umif_front_end, one clock, sync reset
`timescale 1ns/10ps
`include "umif_regs.vh"
module umif_fe_chk (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// requests
	input wire busResetDet,
	input wire tokValid,
	input wire [6:0] tokAddr,
	input wire setAddrValid,
	input wire [6:0] setAddrVal,
	input wire descReq,
	input wire [7:0] descType,
	// answers
	input wire dmPullupEn_r,
	input wire tokAccept_r,
	input wire descAck_r,
	input wire descStall_r,
	input wire [1:0] descSel_r,
	input wire [6:0] devAddr_r,
	input wire [1:0] linkState_r,
	input wire fiveButtonMode_r,
	input wire [15:0] vendorId_r,
	input wire [15:0] productId_r,
	input wire [4:0] buttonsPressed_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ============================================================
	// a request only counts while the link is live and aimed at our address
	wire live = linkState_r != `UMIF_ST_POWERED && !busResetDet;
	wire hit = live && tokAddr == devAddr_r;
	wire known = descType == `UMIF_DESC_DEVICE || descType == `UMIF_DESC_CONFIG ||
		descType == `UMIF_DESC_HID_REPORT;
	sequence descHit(t);
		descReq && hit && descType == t;
	endsequence
	chk_tok_accept: assert property (tokValid && hit |=> tokAccept_r)
		else $error("token to own address not accepted");
	chk_tok_refuse: assert property (tokValid && tokAddr != devAddr_r |=> !tokAccept_r)
		else $error("token to foreign address accepted");
	chk_powered_quiet: assert property ((tokValid || descReq) &&
		linkState_r == `UMIF_ST_POWERED |=> !tokAccept_r && !descAck_r)
		else $error("answer before bus reset");
	chk_pullup_attach: assert property ($fell(sys_rst) |-> ##2 dmPullupEn_r)
		else $error("pull-up not enabled after reset");
	chk_pullup_hold: assert property (dmPullupEn_r |=> dmPullupEn_r)
		else $error("pull-up dropped");
	chk_desc_device: assert property (descHit(`UMIF_DESC_DEVICE) |=>
		descAck_r && descSel_r == `UMIF_SEL_DEVICE)
		else $error("device descriptor not answered");
	chk_desc_report: assert property (descHit(`UMIF_DESC_HID_REPORT) |=>
		descAck_r && descSel_r == `UMIF_SEL_REPORT)
		else $error("report descriptor not answered");
	chk_desc_stall: assert property (descReq && hit && !known |=> descStall_r && !descAck_r)
		else $error("unknown descriptor not stalled");
	chk_set_addr: assert property (setAddrValid && !busResetDet &&
		setAddrVal != 7'h00 && linkState_r == `UMIF_ST_DEFAULT |=>
		devAddr_r == $past(setAddrVal) && linkState_r == `UMIF_ST_ADDRESSED)
		else $error("new address not taken");
	chk_bus_reset: assert property (busResetDet |=>
		linkState_r == `UMIF_ST_DEFAULT && devAddr_r == `UMIF_DEFAULT_ADDR)
		else $error("bus reset not honoured");
	chk_product_id: assert property (vendorId_r == `UMIF_VENDOR_ID |->
		productId_r == (fiveButtonMode_r ? `UMIF_PRODUCT_5BTN : `UMIF_PRODUCT_3BTN))
		else $error("identity does not match mode");
	chk_strap_mask: assert property (!fiveButtonMode_r |-> buttonsPressed_r[4:3] == 2'h0)
		else $error("strap reported as button");
endmodule // umif_fe_chk

bind umif_front_end umif_fe_chk u_chk (.clk(clk), .sys_rst(sys_rst),
	.busResetDet(busResetDet), .tokValid(tokValid), .tokAddr(tokAddr),
	.setAddrValid(setAddrValid), .setAddrVal(setAddrVal), .descReq(descReq),
	.descType(descType), .dmPullupEn_r(dmPullupEn_r), .tokAccept_r(tokAccept_r),
	.descAck_r(descAck_r), .descStall_r(descStall_r), .descSel_r(descSel_r),
	.devAddr_r(devAddr_r), .linkState_r(linkState_r), .fiveButtonMode_r(fiveButtonMode_r),
	.vendorId_r(vendorId_r), .productId_r(productId_r), .buttonsPressed_r(buttonsPressed_r));

// file: dv/umif_host_model.sv
// host side model: issues packet engine requests as one-cycle pulses
// assumes its task is called just after a rising clk edge
`timescale 1ns/10ps
module umif_host_model (
	// clock
	input wire clk,
	// requests toward the front end
	output reg busResetDet,
	output reg tokValid,
	output reg [6:0] tokAddr,
	output reg setAddrValid,
	output reg [6:0] setAddrVal,
	output reg descReq,
	output reg [7:0] descType,
	output reg reportTake
);
	// ============================================================
	// no token, set-address or descriptor request before a bus reset; earlyOk lets tokens through early, report takes always pass
	reg rstSeen_r = 1'b0;
	reg earlyOk = 1'b0;
	initial begin
		{busResetDet, tokValid, setAddrValid, descReq, reportTake} = 5'h0;
		{tokAddr, setAddrVal, descType} = 22'h2a5a5a;
	end
	// idle edge, one request edge, then the released fields are scrambled
	task pulse(input [2:0] k, input [6:0] a, input [7:0] t);
		begin
			@(posedge clk);
			#1;
			{tokAddr, setAddrVal, descType} = {a, a, t};
			busResetDet = k == 3'h0;
			tokValid = k == 3'h1 && (rstSeen_r || earlyOk);
			setAddrValid = k == 3'h2 && rstSeen_r;
			descReq = k == 3'h3 && rstSeen_r;
			reportTake = k == 3'h4;
			@(posedge clk);
			#1;
			rstSeen_r = rstSeen_r || k == 3'h0;
			{busResetDet, tokValid, setAddrValid, descReq, reportTake} = 5'h0;
			{tokAddr, setAddrVal, descType} = ~{a, a, t};
		end
	endtask
endmodule // umif_host_model

// file: dv/umif_front_end_tb.sv
// self-checking bench for the mouse front end
// assumes the host model on the request side and the bound checker
`timescale 1ns/10ps
`include "umif_regs.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
	$display("unexpected at %0t: output differs", $time); end end
module umif_front_end_tb;
	// ============================================================
	// stimulus and observed outputs
	reg clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [2:0] btnN = 3'h7;
	reg [1:0] strapN = 2'h3;
	reg fiveSel = 1'b0;
	reg [1:0] wheel = 2'h3;
	int err_total = 0;
	int compares = 0;
	int cycles = 0;
	wire busResetDet, tokValid, setAddrValid, descReq, reportTake;
	wire [6:0] tokAddr, setAddrVal, devAddr_r;
	wire [7:0] descType, wheelDelta_r;
	wire dmPullupEn_r, tokAccept_r, descAck_r, descStall_r, enumDone_r;
	wire fiveButtonMode_r, reportPending_r;
	wire [1:0] descSel_r, linkState_r;
	wire [15:0] vendorId_r, productId_r;
	wire [4:0] buttonsPressed_r;
	umif_host_model u_host (.clk(clk), .busResetDet(busResetDet), .tokValid(tokValid),
		.tokAddr(tokAddr), .setAddrValid(setAddrValid), .setAddrVal(setAddrVal),
		.descReq(descReq), .descType(descType), .reportTake(reportTake));
	// short debounce keeps the run brief; timing below follows from 8
	umif_front_end #(.DEBOUNCE_CYC(22'h8)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.button_input_1(btnN[0]), .button_input_2(btnN[1]), .button_input_3(btnN[2]),
		.option_strap_0(strapN[0]), .option_strap_1(strapN[1]), .fiveButtonSel(fiveSel),
		.wheel_phase_a(wheel[1]), .wheel_phase_b(wheel[0]), .busResetDet(busResetDet),
		.tokValid(tokValid), .tokAddr(tokAddr), .setAddrValid(setAddrValid),
		.setAddrVal(setAddrVal), .descReq(descReq), .descType(descType),
		.reportTake(reportTake), .dmPullupEn_r(dmPullupEn_r), .tokAccept_r(tokAccept_r),
		.descAck_r(descAck_r), .descStall_r(descStall_r), .descSel_r(descSel_r),
		.devAddr_r(devAddr_r), .linkState_r(linkState_r), .enumDone_r(enumDone_r),
		.fiveButtonMode_r(fiveButtonMode_r), .vendorId_r(vendorId_r),
		.productId_r(productId_r), .reportPending_r(reportPending_r),
		.buttonsPressed_r(buttonsPressed_r), .wheelDelta_r(wheelDelta_r));
	// clock and hang guard
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			print_verdict;
		end
	end
	task print_verdict;
		begin
			if (err_total == 0 && compares > 0) begin
				$display("STATUS OK");
			end else begin
				$display("STATUS NOT OK");
			end
			$finish;
		end
	endtask
	task cyc(input int n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	// ============================================================
	// scenarios
	task do_reset(input five);
		begin
			fiveSel = five;
			sys_rst = 1'b1;
			cyc(5);
			sys_rst = 1'b0;
			cyc(2);
			`CHK(dmPullupEn_r, 1'b1)
			`CHK(vendorId_r, `UMIF_VENDOR_ID)
			`CHK(productId_r, five ? `UMIF_PRODUCT_5BTN : `UMIF_PRODUCT_3BTN)
			`CHK(linkState_r, `UMIF_ST_POWERED)
		end
	endtask
	task t_powered;
		begin
			u_host.earlyOk = 1'b1;
			u_host.pulse(3'h1, 7'h00, 8'h00);
			`CHK(tokAccept_r, 1'b0)
			u_host.earlyOk = 1'b0;
		end
	endtask
	task t_enum;
		begin
			u_host.pulse(3'h0, 7'h00, 8'h00);
			`CHK(linkState_r, `UMIF_ST_DEFAULT)
			u_host.pulse(3'h3, 7'h00, `UMIF_DESC_DEVICE);
			`CHK(descSel_r, `UMIF_SEL_DEVICE)
			u_host.pulse(3'h3, 7'h00, `UMIF_DESC_CONFIG);
			`CHK(descSel_r, `UMIF_SEL_CONFIG)
			u_host.pulse(3'h3, 7'h00, 8'h07);
			`CHK(descStall_r, 1'b1)
			u_host.pulse(3'h2, 7'h05, 8'h00);
			`CHK(devAddr_r, 7'h05)
			u_host.pulse(3'h1, 7'h00, 8'h00);
			`CHK(tokAccept_r, 1'b0)
			u_host.pulse(3'h1, 7'h05, 8'h00);
			`CHK(tokAccept_r, 1'b1)
			u_host.pulse(3'h3, 7'h05, `UMIF_DESC_HID_REPORT);
			`CHK(descSel_r, `UMIF_SEL_REPORT)
			cyc(1);
			`CHK(enumDone_r, 1'b1)
		end
	endtask
	task t_buttons;
		begin
			btnN = 3'h6;
			cyc(6);
			`CHK(buttonsPressed_r[0], 1'b0)
			cyc(6);
			`CHK(buttonsPressed_r[0], 1'b1)
			`CHK(reportPending_r, 1'b1)
			u_host.pulse(3'h4, 7'h00, 8'h00);
			`CHK(reportPending_r, 1'b0)
			btnN = 3'h2;
			cyc(3);
			btnN = 3'h6;
			cyc(14);
			`CHK(buttonsPressed_r, 5'h01)
			btnN = 3'h0;
			cyc(12);
			`CHK(buttonsPressed_r, 5'h07)
			btnN = 3'h7;
			strapN = 2'h2;
			cyc(12);
			`CHK(buttonsPressed_r, 5'h00)
			strapN = 2'h3;
		end
	endtask
	task t_wheel;
		begin
			wheel = 2'h2;
			cyc(1);
			wheel = 2'h0;
			cyc(3);
			`CHK(wheelDelta_r, 8'h01)
			wheel = 2'h3;
			cyc(3);
			`CHK(wheelDelta_r, 8'h01)
			wheel = 2'h1;
			cyc(1);
			wheel = 2'h0;
			cyc(3);
			`CHK(wheelDelta_r, 8'h00)
			wheel = 2'h2;
			cyc(1);
			wheel = 2'h3;
			cyc(3);
			`CHK(wheelDelta_r, 8'hff)
			u_host.pulse(3'h4, 7'h00, 8'h00);
			`CHK(wheelDelta_r, 8'h00)
		end
	endtask
	// a bus reset from the enumerated state drops the address and the report
	task t_rebus;
		begin
			btnN = 3'h6;
			cyc(12);
			`CHK(reportPending_r, 1'b1)
			u_host.pulse(3'h0, 7'h00, 8'h00);
			`CHK(linkState_r, `UMIF_ST_DEFAULT)
			`CHK(devAddr_r, `UMIF_DEFAULT_ADDR)
			u_host.pulse(3'h1, 7'h05, 8'h00);
			`CHK(tokAccept_r, 1'b0)
			`CHK(reportPending_r, 1'b0)
			u_host.pulse(3'h2, 7'h00, 8'h00);
			`CHK(linkState_r, `UMIF_ST_DEFAULT)
			u_host.pulse(3'h1, 7'h00, 8'h00);
			`CHK(tokAccept_r, 1'b1)
			btnN = 3'h7;
		end
	endtask
	task t_five;
		begin
			do_reset(1'b1);
			strapN = 2'h1;
			cyc(12);
			`CHK(buttonsPressed_r, 5'h10)
			strapN = 2'h0;
			btnN = 3'h6;
			cyc(12);
			`CHK(buttonsPressed_r, 5'h19)
		end
	endtask
	initial begin
		do_reset(1'b0);
		t_powered;
		t_enum;
		t_buttons;
		t_wheel;
		t_rebus;
		t_five;
		print_verdict;
	end
endmodule // umif_front_end_tb
